// >>> inc/scan_port_consts.svh
// offsets, field positions, reset values and timing counts of the host port
`ifndef SCAN_PORT_CONSTS_SVH
`define SCAN_PORT_CONSTS_SVH
`define REG_PIXEL 8'h00
`define REG_STATUS 8'h02
`define REG_TSEL 8'h03
`define REG_TPTR_LO 8'h04
`define REG_TPTR_HI 8'h05
`define REG_TPORT 8'h06
`define REG_CMD 8'h07
`define REG_CFG 8'h42
`define REG_FEED 8'h10
`define REG_HOLD 8'h11
`define REG_VSTART 8'h12
`define REG_VEND 8'h13
`define REG_FMT 8'h14
`define CMD_SCAN_BIT 3
`define CFG_NIBBLE_BIT 0
`define TSEL_OG_BIT 0
`define TPTR_RD_BIT 7
`define FMT_COLOR3_BIT 2
`define FMT_PS1_BIT 4
`define FMT_PS2_BIT 5
`define NIB_IDLE 4'h9
`define VEND_RST 8'hFF
`define LB_DEPTH 64
`define LB_AW 6
`define LB_HALT_LVL 7'h3F
`define CLK_NS 50
`define STEP_NS 40000
`define STEP_CYC ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_UNIT_NS 1000000
`endif

// >>> inc/scan_port_pkg.sv
// types shared by the host read port and its helpers
package scan_port_pkg;
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_WHOLD = 5'b00010,
    H_RDRIVE = 5'b00100,
    H_RBUSY = 5'b01000,
    H_REND = 5'b10000
  } host_st_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FEED = 4'b0010,
    S_ACQ = 4'b0100,
    S_HALT = 4'b1000
  } scan_st_t;
  // host pins after the synchroniser
  typedef struct packed {
    logic ifsel;
    logic [1:0] ps;
    logic init_n;
    logic selin_n;
    logic autofeed_n;
    logic strobe_n;
    logic [7:0] data;
  } pins_t;
  // status lines back to the host
  typedef struct packed {
    logic busy;
    logic ack;
    logic pe;
    logic select;
    logic error;
  } stat_pins_t;
endpackage

// >>> hw/pin_sync3.sv
// three-flop synchroniser with agreement filter for host pins
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int W = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and filtered copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;
  sync_st_t r_r, r_nxt;

  // ----------------------------------------
  // a bit changes only once stages two and three agree
  // ----------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.q[i] = r_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.q;
endmodule

// >>> hw/pixel_packer.sv
// windows sensor samples and packs low-depth pixels into bytes
`timescale 1ns/10ps
module pixel_packer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sensor stream
  input wire logic pix_valid,
  input wire logic [7:0] pix,
  input wire logic line_end,
  // format
  input wire logic [1:0] depth,
  input wire logic color3,
  input wire logic [7:0] vstart,
  input wire logic [7:0] vend,
  // packed bytes
  output logic byte_valid,
  output logic [7:0] byte_data
);
  typedef struct packed {
    logic [7:0] idx;
    logic [1:0] sub;
    logic [7:0] acc;
    logic [3:0] nbits;
    logic bv;
    logic [7:0] bd;
  } pack_st_t;
  pack_st_t r_r, r_nxt;
  logic [3:0] bits;

  // depth code 0..3 means 8, 4, 2, 1 bits per pixel
  always_comb begin
    bits = 4'h8 >> depth;
    r_nxt = r_r;
    r_nxt.bv = 1'b0;
    if (line_end) begin
      // flush a part byte, pixels left-aligned
      if (r_r.nbits != 4'h0) begin
        r_nxt.bv = 1'b1;
        r_nxt.bd = r_r.acc << (4'h8 - r_r.nbits);
      end
      r_nxt.idx = 8'h00;
      r_nxt.sub = 2'h0;
      r_nxt.nbits = 4'h0;
      r_nxt.acc = 8'h00;
    end else if (pix_valid) begin
      if (r_r.idx >= vstart && r_r.idx <= vend) begin
        if (depth == 2'h0) begin
          r_nxt.bv = 1'b1;
          r_nxt.bd = pix;
        end else begin
          r_nxt.acc = (r_r.acc << bits) | (pix >> (4'h8 - bits));
          r_nxt.nbits = r_r.nbits + bits;
          if (r_r.nbits + bits == 4'h8) begin
            r_nxt.bv = 1'b1;
            r_nxt.bd = (r_r.acc << bits) | (pix >> (4'h8 - bits));
            r_nxt.nbits = 4'h0;
          end
        end
      end
      // interleaved colour shares one pixel index
      if (color3 && r_r.sub != 2'h2) begin
        r_nxt.sub = r_r.sub + 2'h1;
      end else begin
        r_nxt.sub = 2'h0;
        r_nxt.idx = r_r.idx + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign byte_valid = r_r.bv;
  assign byte_data = r_r.bd;
endmodule

// >>> hw/scanner_host_read_port.sv
// host data port of the scanner: parallel and micro bus access, table port, scan data path
`timescale 1ns/10ps
`include "scan_port_consts.svh"
module scanner_host_read_port #(
  parameter int HOLD_UNIT_CYC = `HOLD_UNIT_NS / `CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host data pins
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe,
  // host control pins
  input wire logic strobe_n,
  input wire logic autofeed_n,
  input wire logic selin_n,
  input wire logic init_n,
  output scan_port_pkg::stat_pins_t stat,
  // strap and paper sensors
  input wire logic interface_select_pin,
  input wire logic [1:0] paper_sensor,
  // table memory
  output logic [16:0] tbl_addr,
  output logic tbl_og,
  output logic tbl_we,
  output logic [15:0] tbl_wdata,
  input wire logic [15:0] tbl_rdata,
  // sensor stream
  output logic acq_en,
  input wire logic pix_valid,
  input wire logic [7:0] pix,
  input wire logic line_end,
  input wire logic pause_req,
  // motor
  output logic motor_step,
  output logic motor_on
);
  typedef struct packed {
    scan_port_pkg::host_st_t hst;
    scan_port_pkg::scan_st_t sst;
    logic busy;
    logic oe;
    logic [3:0] nib;
    logic [7:0] dout;
    logic [7:0] addr;
    logic [7:0] tsel;
    logic [7:0] cmd;
    logic [7:0] cfg;
    logic [7:0] feed;
    logic [7:0] hold;
    logic [7:0] vstart;
    logic [7:0] vend;
    logic [7:0] fmt;
    logic [14:0] tptr;
    logic trd;
    logic half;
    logic tinc;
    logic [7:0] wlo;
    logic [15:0] pre;
    logic twe;
    logic [15:0] twd;
    logic [3:0] prev;
    logic [1:0] ps_prev;
    logic [`LB_DEPTH-1:0][7:0] mem;
    logic [`LB_AW-1:0] wp;
    logic [`LB_AW-1:0] rp;
    logic [`LB_AW:0] cnt;
    logic [7:0] steps;
    logic [9:0] tmr;
    logic step;
    logic mon;
    logic [15:0] ucnt;
    logic [7:0] hcnt;
    logic lpause;
    logic le_d;
  } port_st_t;

  localparam port_st_t ST_RST = '{
    hst: scan_port_pkg::H_IDLE,
    sst: scan_port_pkg::S_IDLE,
    nib: `NIB_IDLE,
    // pins idle high, so no false edge after reset
    prev: 4'hF,
    vend: `VEND_RST,
    default: '0
  };

  port_st_t r_r, r_nxt;
  scan_port_pkg::pins_t p;
  logic pk_v;
  logic [7:0] pk_d;
  logic up_mode, cs, ev_addr, ev_wr, ev_rd, push, pop, og, scanning;
  logic [7:0] pbyte, rbyte;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // every host pin passes three synchroniser flops and the filter flop
  pin_sync3 #(
    .W($bits(scan_port_pkg::pins_t))
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({interface_select_pin, paper_sensor, init_n, selin_n, autofeed_n, strobe_n, d_in}),
    .q(p)
  );

  pixel_packer u_pack (
    .clk(clk),
    .rstn(rstn),
    .pix_valid(pix_valid),
    .pix(pix),
    .line_end(line_end),
    .depth(r_r.fmt[1:0]),
    .color3(r_r.fmt[`FMT_COLOR3_BIT]),
    .vstart(r_r.vstart),
    .vend(r_r.vend),
    .byte_valid(pk_v),
    .byte_data(pk_d)
  );

  // status register image, also used as the per-line trailer
  function automatic logic [7:0] stat_byte(input port_st_t s, input logic pause);
    stat_byte = {2'b00, p.ps, pause, (s.cnt == '0), (s.cnt == `LB_DEPTH),
                 (s.sst != scan_port_pkg::S_IDLE)};
  endfunction

  // ----------------------------------------
  // host protocol, registers, buffer and scan control
  // ----------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.twe = 1'b0;
    r_nxt.step = 1'b0;
    r_nxt.tinc = 1'b0;
    // a write pulse keeps its address; the pointer moves a cycle later
    if (r_r.tinc) begin
      r_nxt.tptr = r_r.tptr + 15'h0001;
    end
    ev_addr = 1'b0;
    ev_wr = 1'b0;
    ev_rd = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    pbyte = 8'h00;
    og = r_r.tsel[`TSEL_OG_BIT];
    scanning = (r_r.sst != scan_port_pkg::S_IDLE);
    up_mode = p.ifsel;
    cs = !p.init_n;
    r_nxt.prev = {p.init_n, p.selin_n, p.autofeed_n, p.strobe_n};
    if (up_mode) begin
      // select-in latches address, strobe writes, autofeed reads
      if (cs && r_r.prev[2] && !p.selin_n) begin
        ev_addr = 1'b1;
      end
      if (cs && !r_r.prev[0] && p.strobe_n) begin
        ev_wr = 1'b1;
      end
      if (cs && r_r.prev[1] && !p.autofeed_n) begin
        ev_rd = 1'b1;
      end
      r_nxt.oe = cs && !p.autofeed_n;
      r_nxt.busy = 1'b0;
      r_nxt.hst = scan_port_pkg::H_IDLE;
    end else begin
      case (r_r.hst)
        scan_port_pkg::H_IDLE: begin
          // address phase of reads and writes alike
          if (!p.strobe_n && !p.selin_n) begin
            ev_addr = 1'b1;
            r_nxt.busy = 1'b1;
            r_nxt.hst = scan_port_pkg::H_WHOLD;
          end else if (!p.strobe_n && !p.autofeed_n) begin
            ev_wr = 1'b1;
            r_nxt.busy = 1'b1;
            r_nxt.hst = scan_port_pkg::H_WHOLD;
          end else if (p.strobe_n && !p.autofeed_n) begin
            ev_rd = 1'b1;
            r_nxt.hst = scan_port_pkg::H_RDRIVE;
          end
        end
        scan_port_pkg::H_WHOLD: begin
          // busy drops once both latch strobes are released
          if (p.selin_n && p.autofeed_n) begin
            r_nxt.busy = 1'b0;
            r_nxt.hst = scan_port_pkg::H_IDLE;
          end
        end
        scan_port_pkg::H_RDRIVE: begin
          // data stood a cycle before busy rises
          r_nxt.busy = 1'b1;
          r_nxt.hst = scan_port_pkg::H_RBUSY;
        end
        scan_port_pkg::H_RBUSY: begin
          if (p.autofeed_n) begin
            // second nibble first, busy low next
            if (r_r.cfg[`CFG_NIBBLE_BIT]) begin
              r_nxt.nib = r_r.dout[7:4];
            end else begin
              // float the bus before busy falls
              r_nxt.oe = 1'b0;
            end
            r_nxt.hst = scan_port_pkg::H_REND;
          end
        end
        scan_port_pkg::H_REND: begin
          r_nxt.busy = 1'b0;
          r_nxt.hst = scan_port_pkg::H_IDLE;
        end
        default: begin
          r_nxt.hst = scan_port_pkg::H_IDLE;
        end
      endcase
    end

    // address latch; a table address latch primes the prefetch
    if (ev_addr) begin
      r_nxt.addr = p.data;
      if (p.data == `REG_TPORT) begin
        r_nxt.pre = tbl_rdata;
      end
    end

    // data phases use the last latched address
    if (ev_rd) begin
      case (r_r.addr)
        `REG_PIXEL: begin
          pbyte = r_r.mem[r_r.rp];
          pop = (r_r.cnt != '0);
        end
        `REG_STATUS: pbyte = stat_byte(r_r, r_r.sst == scan_port_pkg::S_HALT);
        `REG_TSEL: pbyte = r_r.tsel;
        `REG_TPTR_LO: pbyte = r_r.tptr[7:0];
        `REG_TPTR_HI: pbyte = {r_r.trd, r_r.tptr[14:8]};
        // table port reads follow their own sequencing
        `REG_TPORT: begin
          if (og) begin
            pbyte = r_r.half ? r_r.pre[15:8] : r_r.pre[7:0];
          end else begin
            pbyte = tbl_rdata[7:0];
          end
        end
        `REG_CMD: pbyte = r_r.cmd;
        `REG_CFG: pbyte = r_r.cfg;
        `REG_FEED: pbyte = r_r.feed;
        `REG_HOLD: pbyte = r_r.hold;
        `REG_VSTART: pbyte = r_r.vstart;
        `REG_VEND: pbyte = r_r.vend;
        `REG_FMT: pbyte = r_r.fmt;
        default: pbyte = 8'h00;
      endcase
      r_nxt.dout = pbyte;
      if (!up_mode && r_r.cfg[`CFG_NIBBLE_BIT]) begin
        // first nibble on the status lines
        r_nxt.nib = pbyte[3:0];
      end else if (!up_mode) begin
        r_nxt.oe = 1'b1;
      end
    end

    if (ev_wr) begin
      case (r_r.addr)
        `REG_TSEL: r_nxt.tsel = p.data;
        `REG_TPTR_LO: r_nxt.tptr[7:0] = p.data;
        `REG_TPTR_HI: begin
          r_nxt.tptr[14:8] = p.data[6:0];
          r_nxt.trd = p.data[`TPTR_RD_BIT];
        end
        `REG_TPORT: begin
          if (!r_r.trd && (!og || r_r.half)) begin
            r_nxt.twe = 1'b1;
            r_nxt.twd = og ? {p.data, r_r.wlo} : {8'h00, p.data};
          end
          r_nxt.wlo = p.data;
        end
        `REG_CMD: r_nxt.cmd = p.data;
        `REG_CFG: r_nxt.cfg = p.data;
        `REG_FEED: r_nxt.feed = p.data;
        `REG_HOLD: r_nxt.hold = p.data;
        `REG_VSTART: r_nxt.vstart = p.data;
        `REG_VEND: r_nxt.vend = p.data;
        `REG_FMT: r_nxt.fmt = p.data;
        default: begin
        end
      endcase
    end

    // pointer steps per byte for gamma, per word for offset/gain
    if ((ev_wr || ev_rd) && r_r.addr == `REG_TPORT) begin
      if (og) begin
        r_nxt.half = !r_r.half;
      end
      if (!og || r_r.half) begin
        r_nxt.tinc = 1'b1;
      end
    end
    if (ev_wr && (r_r.addr == `REG_TPTR_LO || r_r.addr == `REG_TPTR_HI
        || r_r.addr == `REG_TSEL)) begin
      r_nxt.half = 1'b0;
    end

    // ----------------------------------------
    // line buffer
    // ----------------------------------------
    // trailer byte the cycle after the line ends
    r_nxt.le_d = line_end && scanning;
    if (pause_req || r_r.sst == scan_port_pkg::S_HALT) begin
      r_nxt.lpause = 1'b1;
    end
    // bytes stored strictly in arrival order
    if (r_r.le_d && !(pk_v && scanning)) begin
      push = 1'b1;
      r_nxt.mem[r_r.wp] = stat_byte(r_r, r_r.lpause);
      r_nxt.lpause = pause_req;
    end else if (pk_v && scanning) begin
      push = 1'b1;
      r_nxt.mem[r_r.wp] = pk_d;
      // a flushed part byte goes first, the trailer waits a cycle
      r_nxt.le_d = r_nxt.le_d || r_r.le_d;
    end
    if (push && r_r.cnt == `LB_DEPTH) begin
      push = 1'b0;
    end
    if (push) begin
      r_nxt.wp = r_r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = r_r.rp + 1'b1;
    end
    r_nxt.cnt = r_r.cnt + {{`LB_AW{1'b0}}, push} - {{`LB_AW{1'b0}}, pop};

    // ----------------------------------------
    // scan control
    // ----------------------------------------
    r_nxt.ps_prev = p.ps;
    if (ev_wr && r_r.addr == `REG_CMD) begin
      if (p.data[`CMD_SCAN_BIT] && !r_r.cmd[`CMD_SCAN_BIT]) begin
        // buffer cleared only on scan start
        r_nxt.wp = '0;
        r_nxt.rp = '0;
        r_nxt.cnt = '0;
        r_nxt.lpause = 1'b0;
        r_nxt.sst = scan_port_pkg::S_FEED;
        r_nxt.steps = r_r.feed;
        r_nxt.tmr = '0;
        r_nxt.mon = 1'b1;
      end else if (!p.data[`CMD_SCAN_BIT]) begin
        // a command with the scan bit clear ends the scan
        r_nxt.sst = scan_port_pkg::S_IDLE;
      end
    end else begin
      case (r_r.sst)
        scan_port_pkg::S_FEED: begin
          if (r_r.steps == 8'h00) begin
            r_nxt.sst = scan_port_pkg::S_ACQ;
          end else if (r_r.tmr == 10'(`STEP_CYC - 1)) begin
            r_nxt.tmr = '0;
            r_nxt.step = 1'b1;
            r_nxt.steps = r_r.steps - 8'h01;
          end else begin
            r_nxt.tmr = r_r.tmr + 10'h001;
          end
        end
        scan_port_pkg::S_ACQ: begin
          // stop acquiring near full, room kept for a trailer
          if (r_r.cnt >= `LB_HALT_LVL) begin
            r_nxt.sst = scan_port_pkg::S_HALT;
            r_nxt.ucnt = '0;
            r_nxt.hcnt = '0;
          end
        end
        scan_port_pkg::S_HALT: begin
          // motor off after the hold time, resume once drained
          if (r_r.cnt == '0) begin
            r_nxt.sst = scan_port_pkg::S_ACQ;
            r_nxt.mon = 1'b1;
          end else if (r_r.hcnt >= r_r.hold) begin
            r_nxt.mon = 1'b0;
          end else if (r_r.ucnt == 16'(HOLD_UNIT_CYC - 1)) begin
            r_nxt.ucnt = '0;
            r_nxt.hcnt = r_r.hcnt + 8'h01;
          end else begin
            r_nxt.ucnt = r_r.ucnt + 16'h0001;
          end
        end
        default: begin
        end
      endcase
      // enabled paper sensor change stops the scan
      if (scanning && ((r_r.fmt[`FMT_PS1_BIT] && p.ps[0] != r_r.ps_prev[0])
          || (r_r.fmt[`FMT_PS2_BIT] && p.ps[1] != r_r.ps_prev[1]))) begin
        r_nxt.sst = scan_port_pkg::S_IDLE;
        r_nxt.cmd[`CMD_SCAN_BIT] = 1'b0;
      end
    end
    if (r_nxt.sst == scan_port_pkg::S_IDLE) begin
      r_nxt.mon = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= ST_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign d_out = r_r.dout;
  assign d_oe = r_r.oe;
  assign stat = '{busy: r_r.busy, ack: r_r.nib[3], pe: r_r.nib[2],
                  select: r_r.nib[1], error: r_r.nib[0]};
  assign tbl_addr = {r_r.tsel[2:1], r_r.tptr};
  assign tbl_og = r_r.tsel[`TSEL_OG_BIT];
  assign tbl_we = r_r.twe;
  assign tbl_wdata = r_r.twd;
  assign acq_en = (r_r.sst == scan_port_pkg::S_ACQ);
  assign motor_step = r_r.step;
  assign motor_on = r_r.mon;
endmodule

// >>> dv/scanner_host_read_port_props.sv
// checker of the host port handshake and scan start
`timescale 1ns/10ps
module scanner_host_read_port_props #(
  parameter int HOLD_UNIT_CYC = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host side
  input wire logic d_oe,
  input wire logic strobe_n,
  input wire logic autofeed_n,
  input wire logic selin_n,
  input wire logic interface_select_pin,
  input wire scan_port_pkg::stat_pins_t stat,
  // motor and sensor
  input wire logic motor_step,
  input wire logic acq_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // micro mode has no busy handshake
  wire par = !interface_select_pin;
  oe_then_busy_a:
    assert property ($rose(d_oe) && par |=> stat.busy) else $error("busy late");
  busy_answer_a:
    assert property ($fell(autofeed_n) && strobe_n && !stat.busy && par |-> ##[1:10] stat.busy)
    else $error("no busy answer");
  float_first_a:
    assert property ($fell(stat.busy) && par |-> !d_oe) else $error("bus still driven");
  oe_fall_busy_a:
    assert property ($fell(d_oe) && par |=> $fell(stat.busy)) else $error("busy not lowered");
  read_hold_a:
    assert property (stat.busy && !autofeed_n && strobe_n && par |=> stat.busy)
    else $error("busy dropped early");
  write_hold_a:
    assert property (stat.busy && !selin_n && par |=> stat.busy) else $error("write busy dropped");
  no_clash_a:
    assert property (!strobe_n && par |-> !d_oe) else $error("drive during write");
  feed_first_a:
    assert property (motor_step |-> !acq_en) else $error("acquire during feed");
endmodule

// >>> dv/host_pc_model.sv
// host parallel port model: address, data write and read cycles
`timescale 1ns/10ps
module host_pc_model (
  // clock
  input wire logic clk,
  // data lines
  output wire logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic d_oe,
  // controls and status
  output logic strobe_n,
  output logic autofeed_n,
  output logic selin_n,
  output logic init_n,
  input wire scan_port_pkg::stat_pins_t stat
);
  logic [7:0] hd = 8'hA5;
  int n_to = 0;
  // a released bus shows the inverted last written byte, or the address after a micro read
  assign d_in = d_oe ? d_out : hd;
  initial begin
    strobe_n = 1'b1;
    autofeed_n = 1'b1;
    selin_n = 1'b1;
    init_n = 1'b1;
  end
  task automatic wb(input logic v);
    int i;
    i = 0;
    while (stat.busy !== v && i < 200) begin
      @(posedge clk);
      i++;
    end
    if (i == 200) n_to++;
  endtask
  task automatic wr(input logic a, input logic [7:0] v);
    @(posedge clk);
    strobe_n <= 1'b0;
    hd <= v;
    @(posedge clk);
    if (a) selin_n <= 1'b0;
    else autofeed_n <= 1'b0;
    wb(1'b1);
    strobe_n <= 1'b1;
    selin_n <= 1'b1;
    autofeed_n <= 1'b1;
    wb(1'b0);
    hd <= ~v;
  endtask
  // micro read: select, latch address, then read strobe
  task automatic up_rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    init_n <= 1'b0;
    hd <= a;
    @(posedge clk);
    selin_n <= 1'b0;
    repeat (6) @(posedge clk);
    selin_n <= 1'b1;
    autofeed_n <= 1'b0;
    repeat (7) @(posedge clk);
    r = d_in;
    autofeed_n <= 1'b1;
    init_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // read, nibbles taken at the busy edges
  task automatic rd(input logic nib, output logic [7:0] r);
    @(posedge clk);
    autofeed_n <= 1'b0;
    wb(1'b1);
    r = nib ? {4'h0, stat.ack, stat.pe, stat.select, stat.error} : d_in;
    autofeed_n <= 1'b1;
    wb(1'b0);
    if (nib) r[7:4] = {stat.ack, stat.pe, stat.select, stat.error};
  endtask
endmodule

// >>> dv/scanner_host_read_port_tb.sv
// self-checking bench of the scanner host port
`timescale 1ns/10ps
`include "scan_port_consts.svh"
module scanner_host_read_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pix_valid = 1'b0;
  logic line_end = 1'b0;
  logic [7:0] pix = 8'h00;
  wire logic [7:0] bus, d_out;
  wire logic d_oe, strobe_n, autofeed_n, selin_n, init_n, tbl_og, tbl_we;
  wire logic acq_en, motor_step, motor_on;
  wire scan_port_pkg::stat_pins_t stat;
  wire logic [16:0] tbl_addr;
  wire logic [15:0] tbl_wdata;
  wire logic [15:0] tbl_rdata;
  logic up_pin = 1'b0;
  logic [1:0] psens = 2'b00;
  // table memory: each word follows its address, so a wrong pointer shows
  assign tbl_rdata = 16'h1234 + {8'h00, tbl_addr[7:0]};
  logic [16:0] wa[$];
  logic [15:0] wd[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int nstep = 0;
  always #25 clk = ~clk;
  scanner_host_read_port #(.HOLD_UNIT_CYC(8)) DUT (.clk, .rstn, .d_in(bus), .d_out, .d_oe,
    .strobe_n, .autofeed_n, .selin_n, .init_n, .stat, .interface_select_pin(up_pin),
    .paper_sensor(psens), .tbl_addr, .tbl_og, .tbl_we, .tbl_wdata, .tbl_rdata,
    .acq_en, .pix_valid, .pix, .line_end, .pause_req(1'b0), .motor_step, .motor_on);
  host_pc_model HOST (.clk, .d_in(bus), .d_out, .d_oe, .strobe_n, .autofeed_n, .selin_n,
    .init_n, .stat);
  always @(posedge clk) begin
    if (tbl_we === 1'b1) begin
      wa.push_back(tbl_addr);
      wd.push_back(tbl_wdata);
    end
    if (motor_step === 1'b1) nstep++;
  end
  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rc(input logic nib, input logic [7:0] e);
    logic [7:0] r;
    HOST.rd(nib, r);
    chk({9'h0, e}, {9'h0, r});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    HOST.wr(1'b1, a);
    HOST.wr(1'b0, v);
  endtask
  task automatic t_reg;
    wreg(`REG_VSTART, 8'h5A);
    rc(1'b0, 8'h5A);
    rc(1'b0, 8'h5A);
    HOST.wr(1'b1, 8'h77);
    rc(1'b0, 8'h00);
    wreg(`REG_CFG, 8'h01);
    HOST.wr(1'b1, `REG_VSTART);
    rc(1'b1, 8'h5A);
    wreg(`REG_CFG, 8'h00);
    $display("t_reg end");
  endtask
  task automatic t_up;
    logic [7:0] r;
    up_pin <= 1'b1;
    HOST.up_rd(`REG_VSTART, r);
    chk(17'h5A, {9'h0, r});
    up_pin <= 1'b0;
    repeat (8) @(posedge clk);
    $display("t_up end");
  endtask
  task automatic t_tbl;
    // selector first, then pointer and direction
    wreg(`REG_TSEL, 8'h00);
    wreg(`REG_TPTR_LO, 8'h00);
    wreg(`REG_TPTR_HI, 8'h00);
    HOST.wr(1'b1, `REG_TPORT);
    for (int i = 0; i < 3; i++) HOST.wr(1'b0, 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 3; i++) chk(17'(i), wa[i]);
    chk(17'h33, {1'b0, wd[2]});
    // offset/gain words pair low byte first
    wreg(`REG_TSEL, 8'h01);
    wreg(`REG_TPTR_LO, 8'h00);
    HOST.wr(1'b1, `REG_TPORT);
    for (int i = 0; i < 4; i++) HOST.wr(1'b0, 8'(8'h44 + 8'h11 * i));
    chk(17'h1, wa[wa.size() - 1]);
    chk(17'h7766, {1'b0, wd[wd.size() - 1]});
    wreg(`REG_TSEL, 8'h00);
    wreg(`REG_TPTR_LO, 8'h00);
    wreg(`REG_TPTR_HI, 8'h80);
    HOST.wr(1'b1, `REG_TPORT);
    rc(1'b0, 8'h34);
    chk(17'h1, tbl_addr);
    wreg(`REG_TSEL, 8'h01);
    HOST.wr(1'b1, `REG_TPORT);
    rc(1'b0, 8'h35);
    HOST.wr(1'b1, `REG_TPORT);
    rc(1'b0, 8'h12);
    chk(17'h2, tbl_addr);
    $display("t_tbl end");
  endtask
  // samples go in sensor order, then the line ends
  task automatic feed_line(input logic [7:0] b, input logic [7:0] s);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pix_valid <= 1'b1;
      pix <= b + 8'(k) * s;
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    line_end <= 1'b1;
    @(posedge clk);
    line_end <= 1'b0;
    HOST.wr(1'b1, `REG_PIXEL);
  endtask
  task automatic t_scan;
    int i;
    wreg(`REG_VSTART, 8'h00);
    wreg(`REG_VEND, 8'h02);
    wreg(`REG_FMT, 8'h00);
    wreg(`REG_FEED, 8'h02);
    wreg(`REG_CMD, 8'h08);
    i = 0;
    while (acq_en !== 1'b1 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    chk(17'h2, 17'(nstep));
    // four samples, the window keeps three
    feed_line(8'hA1, 8'h01);
    for (int k = 0; k < 3; k++) rc(1'b0, 8'hA1 + 8'(k));
    rc(1'b0, 8'h01);
    wreg(`REG_CMD, 8'h00);
    chk(17'h0, {16'h0, acq_en});
    $display("t_scan end");
  endtask
  task automatic t_pack;
    // two 4-bit pixels a byte, a part byte left-aligned
    wreg(`REG_FMT, 8'h11);
    wreg(`REG_FEED, 8'h00);
    wreg(`REG_CMD, 8'h08);
    chk(17'h1, {16'h0, acq_en});
    feed_line(8'h1F, 8'h10);
    rc(1'b0, 8'h12);
    rc(1'b0, 8'h30);
    rc(1'b0, 8'h01);
    // an enabled paper sensor change ends the scan
    psens <= 2'b01;
    repeat (8) @(posedge clk);
    chk(17'h0, {16'h0, acq_en});
    $display("t_pack end");
  endtask
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wreg(`REG_CFG, 8'h00);
    t_reg;
    t_up;
    t_tbl;
    t_scan;
    t_pack;
    chk(17'h0, 17'(HOST.n_to));
    final_report;
  end
  initial begin
    #(50 * 40000);
    n_mismatch++;
    final_report;
  end
endmodule
bind scanner_host_read_port scanner_host_read_port_props #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC))
  u_props (
  .clk, .rstn, .d_oe, .strobe_n, .autofeed_n, .selin_n, .interface_select_pin, .stat,
  .motor_step, .acq_en);
